// File: include/rsc_pkg.sv
// constants and types for the streaming read command block
package rsc_pkg;
  // ==========================================================
  // register selects on the task-file port
  localparam logic [2:0] SEL_FEATURE = 3'h0;
  localparam logic [2:0] SEL_COUNT = 3'h1;
  localparam logic [2:0] SEL_COMMAND = 3'h2;
  localparam logic [2:0] SEL_STATUS = 3'h3;
  localparam logic [2:0] SEL_ERROR = 3'h4;
  localparam logic [2:0] SEL_LOG = 3'h5;
  localparam logic [7:0] CMD_READ_STREAM = 8'h2B;
  // ==========================================================
  // feature flag layout
  localparam int FEAT_EXPEDITE_BIT = 7;
  localparam int FEAT_CONTINUE_BIT = 6;
  localparam int FEAT_NONSEQ_BIT = 5;
  localparam int FEAT_RESUME_BIT = 4;
  localparam int FEAT_STREAM_MSB = 2;
  localparam int FEAT_STREAM_LSB = 0;
  // ==========================================================
  // status and error layouts
  localparam int STAT_OCCUPIED_BIT = 7;
  localparam int STAT_READY_BIT = 6;
  localparam int STAT_STREAM_ERR_BIT = 5;
  localparam int STAT_ERR_BIT = 0;
  localparam int ERR_LINK_CRC_BIT = 7;
  localparam int ERR_MEDIA_FAULT_BIT = 6;
  localparam int ERR_NOT_FOUND_BIT = 4;
  localparam int ERR_REJECTED_BIT = 2;
  localparam int ERR_EXPIRED_BIT = 0;
  localparam logic [1:0] ERRT_LINK_CRC = 2'h0;
  localparam logic [1:0] ERRT_MEDIA_FAULT = 2'h1;
  localparam logic [1:0] ERRT_NOT_FOUND = 2'h2;
  localparam logic [1:0] ERRT_REJECTED = 2'h3;
  localparam logic [7:0] STATUS_RESET = 8'h40;
  localparam logic [7:0] ERROR_RESET = 8'h00;
  // ==========================================================
  // timing and counts
  localparam int CLK_PERIOD_NS = 25;
  localparam int MICROSECOND_NS = 1000;
  localparam int CYCLES_PER_US = MICROSECOND_NS / CLK_PERIOD_NS;
  localparam logic [16:0] FULL_SECTOR_COUNT = 17'h10000;
  localparam int LIMIT_W = 40;
  // ==========================================================
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RUN = 2'b10
  } rsc_state_e;
endpackage

// File: src/rsc_read_stream.sv
// streaming read command decoder, time limit enforcer and data FIFO
//
// Function
// - expedite flag bit 7 asks fastest completion, always inside the time limit
// - continue-on-error flag bit 6 keeps the command running through errors
// - with continue, errors end clean with stream error set and type logged
// - with continue, expiry halts, stream error set, expired bit logged
// - device always tries to move the whole request before the limit
// - resume flag bit 4 lets recovery continue from last reported error
// - stream selector bits 2..0 choose the per-stream settings used
// - limit in microseconds is previous feature byte times identify time unit
// - zero multiplier falls back to stored per-stream default
// - zero or missing default means no time limit at all
// - timing starts at command write and stops at completion
// - a limit below the built-in minimum is raised to the minimum
// - current count byte is the low eight bits of sector count
// - previous count byte is the high byte; zero total means 65536
`timescale 1ns/10ps

// ==========================================================
// FIFO with registered show-ahead output stage
module rsc_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16,
  parameter int AW = 4
) (
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  input wire logic i_flush,
  input wire logic i_wr_valid,
  output logic o_wr_ready,
  input wire logic [WIDTH-1:0] i_wr_data,
  output logic o_rd_valid,
  output logic [WIDTH-1:0] o_rd_data,
  input wire logic i_rd_ready,
  output logic o_empty
);
  localparam logic [AW:0] DEPTH_C = (AW+1)'(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg, wr_ptr_next, rd_ptr_reg, rd_ptr_next;
  logic [AW:0] count_reg, count_next;
  logic ready_reg, ready_next, out_valid_reg, out_valid_next, empty_reg, empty_next;
  logic [WIDTH-1:0] out_data_reg, out_data_next;
  logic push, pop;

  always_comb begin
    push = i_wr_valid & ready_reg;
    pop = (count_reg != '0) & (~out_valid_reg | i_rd_ready);
    wr_ptr_next = push ? wr_ptr_reg + AW'(1) : wr_ptr_reg;
    rd_ptr_next = pop ? rd_ptr_reg + AW'(1) : rd_ptr_reg;
    count_next = count_reg + (AW+1)'(push) - (AW+1)'(pop);
    out_valid_next = out_valid_reg;
    out_data_next = out_data_reg;
    if (pop) begin
      out_valid_next = 1'b1;
      out_data_next = mem[rd_ptr_reg];
    end else if (i_rd_ready) begin
      out_valid_next = 1'b0;
    end
    if (i_flush) begin
      wr_ptr_next = '0;
      rd_ptr_next = '0;
      count_next = '0;
      out_valid_next = 1'b0;
    end
    // ready is registered so the source sees back-pressure from a flop
    ready_next = count_next != DEPTH_C;
    empty_next = (count_next == '0) & ~out_valid_next;
  end

  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
      ready_reg <= 1'b1;
      out_valid_reg <= 1'b0;
      out_data_reg <= '0;
      empty_reg <= 1'b1;
    end else begin
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
      count_reg <= count_next;
      ready_reg <= ready_next;
      out_valid_reg <= out_valid_next;
      out_data_reg <= out_data_next;
      empty_reg <= empty_next;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (push) begin
      mem[wr_ptr_reg] <= i_wr_data;
    end
  end

  assign o_wr_ready = ready_reg;
  assign o_rd_valid = out_valid_reg;
  assign o_rd_data = out_data_reg;
  assign o_empty = empty_reg;
endmodule // rsc_fifo

// ==========================================================
// command block: task-file writes, limit timer, completion status
module rsc_read_stream #(
  parameter int DATA_W = 16,
  parameter int FIFO_DEPTH = 16,
  parameter int FIFO_AW = 4,
  parameter logic [31:0] TIME_UNIT_US = 32'h0000000A,
  parameter logic [39:0] MIN_LIMIT_US = 40'h00000003E8
) (
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [2:0] i_reg_sel,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  input wire logic i_cfg_wr,
  input wire logic [2:0] i_cfg_stream,
  input wire logic [7:0] i_cfg_default_limit,
  input wire logic i_media_valid,
  input wire logic [DATA_W-1:0] i_media_data,
  output logic o_media_ready,
  input wire logic i_media_sector_done,
  input wire logic i_media_err,
  input wire logic [1:0] i_media_err_type,
  output logic o_media_start,
  output logic o_media_stop,
  output logic [2:0] o_media_stream,
  output logic [16:0] o_media_count,
  output logic o_media_expedite,
  output logic o_media_continue,
  output logic o_media_nonseq,
  output logic o_media_resume,
  output logic o_host_valid,
  output logic [DATA_W-1:0] o_host_data,
  input wire logic i_host_ready,
  output logic [7:0] o_status,
  output logic [7:0] o_error,
  output logic o_busy,
  output logic o_done
);
  localparam logic [5:0] TICK_LAST = 6'(rsc_pkg::CYCLES_PER_US - 1);

  function automatic logic [rsc_pkg::LIMIT_W-1:0] scale_limit(input logic [7:0] mult);
    scale_limit = rsc_pkg::LIMIT_W'({8'h00, TIME_UNIT_US} * {32'h00000000, mult});
  endfunction

  function automatic logic [7:0] err_bit(input logic [1:0] kind);
    err_bit = 8'h00;
    case (kind)
      rsc_pkg::ERRT_LINK_CRC: err_bit[rsc_pkg::ERR_LINK_CRC_BIT] = 1'b1;
      rsc_pkg::ERRT_MEDIA_FAULT: err_bit[rsc_pkg::ERR_MEDIA_FAULT_BIT] = 1'b1;
      rsc_pkg::ERRT_NOT_FOUND: err_bit[rsc_pkg::ERR_NOT_FOUND_BIT] = 1'b1;
      default: err_bit[rsc_pkg::ERR_REJECTED_BIT] = 1'b1;
    endcase
  endfunction

  rsc_pkg::rsc_state_e state_reg, state_next;
  logic [7:0] feat_cur_reg, feat_cur_next, feat_prev_reg, feat_prev_next;
  logic [7:0] cnt_cur_reg, cnt_cur_next, cnt_prev_reg, cnt_prev_next;
  logic [7:0] dflt_reg [8];
  logic [7:0] dflt_next [8];
  logic [7:0] dflt_set_reg, dflt_set_next;
  logic [7:0] error_reg, error_next, log_reg, log_next, rdata_reg, rdata_next;
  logic busy_reg, busy_next, serr_reg, serr_next, err_reg, err_next, done_reg, done_next;
  logic start_reg, start_next, stop_reg, stop_next, flush;
  logic [2:0] stream_reg, stream_next;
  logic [16:0] remain_reg, remain_next, total_reg, total_next;
  logic expedite_reg, expedite_next, cont_reg, cont_next;
  logic nonseq_reg, nonseq_next, resume_reg, resume_next;
  logic seen_err_reg, seen_err_next, timer_on_reg, timer_on_next;
  logic [5:0] tick_reg, tick_next;
  logic [rsc_pkg::LIMIT_W-1:0] left_us_reg, left_us_next, limit;
  logic [2:0] sel_stream;
  logic [7:0] mult;
  logic fifo_empty, finish, expire;

  rsc_fifo #(
    .WIDTH(DATA_W),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_fifo (
    .i_sys_clk(i_sys_clk),
    .i_sys_rst(i_sys_rst),
    .i_flush(flush),
    .i_wr_valid(i_media_valid & (state_reg == rsc_pkg::ST_RUN)),
    .o_wr_ready(o_media_ready),
    .i_wr_data(i_media_data),
    .o_rd_valid(o_host_valid),
    .o_rd_data(o_host_data),
    .i_rd_ready(i_host_ready),
    .o_empty(fifo_empty)
  );

  always_comb begin
    state_next = state_reg;
    feat_cur_next = feat_cur_reg;
    feat_prev_next = feat_prev_reg;
    cnt_cur_next = cnt_cur_reg;
    cnt_prev_next = cnt_prev_reg;
    dflt_next = dflt_reg;
    dflt_set_next = dflt_set_reg;
    error_next = error_reg;
    log_next = log_reg;
    busy_next = busy_reg;
    serr_next = serr_reg;
    err_next = err_reg;
    stream_next = stream_reg;
    remain_next = remain_reg;
    total_next = total_reg;
    expedite_next = expedite_reg;
    cont_next = cont_reg;
    nonseq_next = nonseq_reg;
    resume_next = resume_reg;
    seen_err_next = seen_err_reg;
    timer_on_next = timer_on_reg;
    tick_next = tick_reg;
    left_us_next = left_us_reg;
    rdata_next = rdata_reg;
    done_next = 1'b0;
    start_next = 1'b0;
    stop_next = 1'b0;
    flush = 1'b0;
    finish = 1'b0;
    expire = 1'b0;
    sel_stream = i_reg_wdata[rsc_pkg::FEAT_STREAM_MSB:rsc_pkg::FEAT_STREAM_LSB];
    mult = feat_prev_reg;
    limit = '0;

    if (i_cfg_wr) begin
      dflt_next[i_cfg_stream] = i_cfg_default_limit;
      dflt_set_next[i_cfg_stream] = 1'b1;
    end

    if (i_reg_rd) begin
      case (i_reg_sel)
        rsc_pkg::SEL_COUNT: rdata_next = cnt_cur_reg;
        rsc_pkg::SEL_STATUS: rdata_next = o_status;
        rsc_pkg::SEL_ERROR: rdata_next = error_reg;
        rsc_pkg::SEL_LOG: rdata_next = log_reg;
        default: rdata_next = 8'h00;
      endcase
    end

    case (state_reg)
      rsc_pkg::ST_IDLE: begin
        // each parameter write shifts the older byte into the previous slot
        if (i_reg_wr && i_reg_sel == rsc_pkg::SEL_FEATURE) begin
          feat_prev_next = feat_cur_reg;
          feat_cur_next = i_reg_wdata;
        end
        if (i_reg_wr && i_reg_sel == rsc_pkg::SEL_COUNT) begin
          cnt_prev_next = cnt_cur_reg;
          cnt_cur_next = i_reg_wdata;
        end
        if (i_reg_wr && i_reg_sel == rsc_pkg::SEL_COMMAND) begin
          error_next = 8'h00;
          log_next = 8'h00;
          serr_next = 1'b0;
          err_next = 1'b0;
          if (i_reg_wdata == rsc_pkg::CMD_READ_STREAM) begin
            sel_stream = feat_cur_reg[rsc_pkg::FEAT_STREAM_MSB:rsc_pkg::FEAT_STREAM_LSB];
            stream_next = sel_stream;
            expedite_next = feat_cur_reg[rsc_pkg::FEAT_EXPEDITE_BIT];
            cont_next = feat_cur_reg[rsc_pkg::FEAT_CONTINUE_BIT];
            nonseq_next = feat_cur_reg[rsc_pkg::FEAT_NONSEQ_BIT];
            resume_next = feat_cur_reg[rsc_pkg::FEAT_RESUME_BIT];
            if (mult == 8'h00 && dflt_set_reg[sel_stream]) begin
              mult = dflt_reg[sel_stream];
            end
            limit = scale_limit(mult);
            if (limit != '0 && limit < MIN_LIMIT_US) begin
              limit = MIN_LIMIT_US;
            end
            timer_on_next = limit != '0;
            left_us_next = limit;
            tick_next = '0;
            total_next = {cnt_prev_reg, cnt_cur_reg} == 16'h0000 ? rsc_pkg::FULL_SECTOR_COUNT
                                                                  : {1'b0, cnt_prev_reg, cnt_cur_reg};
            remain_next = total_next;
            seen_err_next = 1'b0;
            busy_next = 1'b1;
            start_next = 1'b1;
            flush = 1'b1;
            state_next = rsc_pkg::ST_RUN;
          end else begin
            error_next[rsc_pkg::ERR_REJECTED_BIT] = 1'b1;
            err_next = 1'b1;
            done_next = 1'b1;
          end
        end
      end
      rsc_pkg::ST_RUN: begin
        if (i_media_sector_done && remain_reg != '0) begin
          remain_next = remain_reg - 17'h00001;
        end
        if (timer_on_reg) begin
          tick_next = tick_reg == TICK_LAST ? 6'h00 : tick_reg + 6'h01;
          if (tick_reg == TICK_LAST) begin
            left_us_next = left_us_reg - 40'h0000000001;
            expire = left_us_reg == 40'h0000000001;
          end
        end
        if (i_media_err && cont_reg) begin
          // keep moving data; the error is logged now, stream error shows only at the end
          log_next = log_reg | err_bit(i_media_err_type);
          seen_err_next = 1'b1;
        end
        if (expire) begin
          finish = 1'b1;
          stop_next = 1'b1;
          if (cont_reg) begin
            log_next = log_next | (8'h01 << rsc_pkg::ERR_EXPIRED_BIT);
            serr_next = 1'b1;
          end else begin
            error_next[rsc_pkg::ERR_EXPIRED_BIT] = 1'b1;
            err_next = 1'b1;
          end
        end else if (i_media_err && !cont_reg) begin
          error_next = err_bit(i_media_err_type);
          err_next = 1'b1;
          finish = 1'b1;
          stop_next = 1'b1;
        end else if (remain_next == '0 && fifo_empty) begin
          // full request delivered, erroneous or not
          finish = 1'b1;
          serr_next = seen_err_next;
        end
        if (finish) begin
          // halted commands drop undelivered words rather than stall the host
          flush = stop_next;
          timer_on_next = 1'b0;
          busy_next = 1'b0;
          done_next = 1'b1;
          state_next = rsc_pkg::ST_IDLE;
        end
      end
      default: begin
        state_next = rsc_pkg::ST_IDLE;
        busy_next = 1'b0;
      end
    endcase
  end

  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state_reg <= rsc_pkg::ST_IDLE;
      feat_cur_reg <= 8'h00;
      feat_prev_reg <= 8'h00;
      cnt_cur_reg <= 8'h00;
      cnt_prev_reg <= 8'h00;
      for (int i = 0; i < 8; i++) begin
        dflt_reg[i] <= 8'h00;
      end
      dflt_set_reg <= 8'h00;
      error_reg <= rsc_pkg::ERROR_RESET;
      log_reg <= 8'h00;
      busy_reg <= 1'b0;
      serr_reg <= 1'b0;
      err_reg <= 1'b0;
      done_reg <= 1'b0;
      start_reg <= 1'b0;
      stop_reg <= 1'b0;
      stream_reg <= 3'h0;
      remain_reg <= 17'h00000;
      total_reg <= 17'h00000;
      expedite_reg <= 1'b0;
      cont_reg <= 1'b0;
      nonseq_reg <= 1'b0;
      resume_reg <= 1'b0;
      seen_err_reg <= 1'b0;
      timer_on_reg <= 1'b0;
      tick_reg <= 6'h00;
      left_us_reg <= '0;
      rdata_reg <= 8'h00;
      o_status <= rsc_pkg::STATUS_RESET;
    end else begin
      state_reg <= state_next;
      feat_cur_reg <= feat_cur_next;
      feat_prev_reg <= feat_prev_next;
      cnt_cur_reg <= cnt_cur_next;
      cnt_prev_reg <= cnt_prev_next;
      dflt_reg <= dflt_next;
      dflt_set_reg <= dflt_set_next;
      error_reg <= error_next;
      log_reg <= log_next;
      busy_reg <= busy_next;
      serr_reg <= serr_next;
      err_reg <= err_next;
      done_reg <= done_next;
      start_reg <= start_next;
      stop_reg <= stop_next;
      stream_reg <= stream_next;
      remain_reg <= remain_next;
      total_reg <= total_next;
      expedite_reg <= expedite_next;
      cont_reg <= cont_next;
      nonseq_reg <= nonseq_next;
      resume_reg <= resume_next;
      seen_err_reg <= seen_err_next;
      timer_on_reg <= timer_on_next;
      tick_reg <= tick_next;
      left_us_reg <= left_us_next;
      rdata_reg <= rdata_next;
      o_status <= {busy_next, 1'b1, serr_next, 4'h0, err_next};
    end
  end

  assign o_reg_rdata = rdata_reg;
  assign o_error = error_reg;
  assign o_busy = busy_reg;
  assign o_done = done_reg;
  assign o_media_start = start_reg;
  assign o_media_stop = stop_reg;
  assign o_media_stream = stream_reg;
  assign o_media_count = total_reg;
  assign o_media_expedite = expedite_reg;
  assign o_media_continue = cont_reg;
  assign o_media_nonseq = nonseq_reg;
  assign o_media_resume = resume_reg;
endmodule // rsc_read_stream

// File: bench/rsc_read_stream_monitor.sv
// assertion checker for the streaming read command block
`timescale 1ns/10ps
module rsc_read_stream_monitor #(
  parameter int DATA_W = 16
) (
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  input wire logic i_reg_wr,
  input wire logic [2:0] i_reg_sel,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_media_err,
  input wire logic i_host_ready,
  input wire logic o_media_start,
  input wire logic o_media_stop,
  input wire logic o_media_continue,
  input wire logic o_host_valid,
  input wire logic [DATA_W-1:0] o_host_data,
  input wire logic [7:0] o_status,
  input wire logic [7:0] o_error,
  input wire logic o_busy,
  input wire logic o_done
);
  // ======
  // properties
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_sys_rst);
  sequence s_cmd_write;
    i_reg_wr && i_reg_sel == rsc_pkg::SEL_COMMAND && !o_busy;
  endsequence
  sequence s_accepted;
    o_busy && o_media_start;
  endsequence
  a_start_accept: assert property (s_cmd_write ##0 i_reg_wdata == rsc_pkg::CMD_READ_STREAM |=>
    s_accepted)
    else $error("command write not accepted one cycle later");
  a_bad_opcode: assert property (s_cmd_write ##0 i_reg_wdata != rsc_pkg::CMD_READ_STREAM |=>
    o_done && !o_busy && o_error[rsc_pkg::ERR_REJECTED_BIT] && o_status[rsc_pkg::STAT_ERR_BIT])
    else $error("unknown opcode not rejected");
  a_busy_rise: assert property ($rose(o_busy) |-> o_media_start)
    else $error("busy rose without a start pulse");
  a_busy_fall: assert property ($fell(o_busy) |-> o_done && !o_status[rsc_pkg::STAT_OCCUPIED_BIT])
    else $error("busy fell without a done pulse");
  a_done_single: assert property (o_done |=> !o_done)
    else $error("done held longer than one cycle");
  a_continue_clean: assert property (o_done && $past(o_busy) && o_media_continue |->
    !o_status[rsc_pkg::STAT_ERR_BIT] && o_error == 8'h00)
    else $error("continue mode ended with error status");
  a_continue_runs: assert property (o_busy && o_media_continue && i_media_err |=> !o_done && !o_media_stop)
    else $error("continue mode stopped on a media error");
  a_error_halts: assert property (o_busy && !o_media_continue && i_media_err |-> ##[1:3] o_done)
    else $error("media error without continue did not end the command");
  a_stream_err: assert property ($rose(o_status[rsc_pkg::STAT_STREAM_ERR_BIT]) |-> o_media_continue && o_done)
    else $error("stream error set outside continue mode");
  a_host_hold: assert property (o_host_valid && !i_host_ready && !o_media_stop && !o_done |=>
    o_media_stop || (o_host_valid && $stable(o_host_data)))
    else $error("host word changed before it was taken");
endmodule // rsc_read_stream_monitor

bind rsc_read_stream rsc_read_stream_monitor #(.DATA_W(DATA_W)) u_mon (.i_sys_clk, .i_sys_rst, .i_reg_wr,
  .i_reg_sel, .i_reg_wdata, .i_media_err, .i_host_ready, .o_media_start, .o_media_stop, .o_media_continue,
  .o_host_valid, .o_host_data, .o_status, .o_error, .o_busy, .o_done);

// File: bench/rsc_host_sink.sv
// host-side data sink model with prompt, slow and stalled modes
`timescale 1ns/10ps
module rsc_host_sink (
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  input wire logic [1:0] i_mode,
  output logic o_ready
);
  // ======
  // ready pattern: 0 always, 1 one cycle in four, else stalled
  logic [1:0] ph_reg;
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ph_reg <= 2'h0;
      o_ready <= 1'b0;
    end else begin
      ph_reg <= ph_reg + 2'h1;
      o_ready <= (i_mode == 2'h0) || (i_mode == 2'h1 && ph_reg == 2'h3);
    end
  end
endmodule // rsc_host_sink

// File: bench/rsc_read_stream_bench.sv
// self-checking bench for the streaming read command block
`timescale 1ns/10ps
module rsc_read_stream_bench;
  // ======
  // signals
  localparam int TU = 1;
  localparam int MINL = 2;
  localparam logic [7:0] CMD = rsc_pkg::CMD_READ_STREAM;
  logic i_sys_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic i_reg_wr = 1'b0, i_reg_rd = 1'b0, i_cfg_wr = 1'b0, i_media_valid = 1'b0;
  logic i_media_sector_done = 1'b0, i_media_err = 1'b0;
  logic [2:0] i_reg_sel = 3'h0, i_cfg_stream = 3'h0, o_media_stream;
  logic [7:0] i_reg_wdata = 8'h00, i_cfg_default_limit = 8'h00, o_reg_rdata, o_status, o_error, f;
  logic [15:0] i_media_data = 16'h0000, o_host_data, n;
  logic [1:0] i_media_err_type = 2'h0, sink_mode = 2'h0;
  logic o_media_ready, o_media_start, o_media_stop, o_media_expedite, o_media_continue, o_media_nonseq;
  logic o_media_resume, o_host_valid, i_host_ready, o_busy, o_done, stop_seen;
  logic [16:0] o_media_count;
  logic [15:0] exp_q[$];
  logic [7:0] mv[3] = '{8'h01, 8'h03, 8'h00};
  logic [7:0] fv[3] = '{8'h40, 8'h00, 8'h42};
  integer seed = 80672;
  int err_total = 0, tests_run = 0, elapsed = 0, cyc = 0, lim, i;
  always #12.5 i_sys_clk = ~i_sys_clk;
  always @(posedge i_sys_clk) cyc <= cyc + 1;
  rsc_read_stream #(.TIME_UNIT_US(32'(TU)), .MIN_LIMIT_US(40'(MINL))) uut (.i_sys_clk, .i_sys_rst, .i_reg_wr,
    .i_reg_rd, .i_reg_sel, .i_reg_wdata, .o_reg_rdata, .i_cfg_wr, .i_cfg_stream, .i_cfg_default_limit,
    .i_media_valid, .i_media_data, .o_media_ready, .i_media_sector_done, .i_media_err, .i_media_err_type,
    .o_media_start, .o_media_stop, .o_media_stream, .o_media_count, .o_media_expedite, .o_media_continue,
    .o_media_nonseq, .o_media_resume, .o_host_valid, .o_host_data, .i_host_ready, .o_status, .o_error,
    .o_busy, .o_done);
  rsc_host_sink u_sink (.i_sys_clk, .i_sys_rst, .i_mode(sink_mode), .o_ready(i_host_ready));
  // ======
  // tasks and expectations
  task automatic chk(input logic [16:0] got, input logic [16:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [2:0] sel, input logic [7:0] d);
    @(posedge i_sys_clk);
    i_reg_wr <= 1'b1;
    i_reg_sel <= sel;
    i_reg_wdata <= d;
    @(posedge i_sys_clk);
    i_reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] sel, input logic [7:0] exp);
    @(posedge i_sys_clk);
    i_reg_rd <= 1'b1;
    i_reg_sel <= sel;
    @(posedge i_sys_clk);
    i_reg_rd <= 1'b0;
    @(posedge i_sys_clk);
    #1 chk(17'(o_reg_rdata), 17'(exp));
  endtask
  task automatic cmd(input logic [7:0] m, input logic [7:0] fl, input logic [15:0] cnt, input logic [7:0] op);
    wr(rsc_pkg::SEL_FEATURE, m);
    wr(rsc_pkg::SEL_FEATURE, fl);
    wr(rsc_pkg::SEL_COUNT, cnt[15:8]);
    wr(rsc_pkg::SEL_COUNT, cnt[7:0]);
    wr(rsc_pkg::SEL_COMMAND, op);
    elapsed = cyc;
  endtask
  task automatic pulse(input int k, input logic err, input logic [1:0] t);
    repeat (k) begin
      @(posedge i_sys_clk);
      i_media_sector_done <= !err;
      i_media_err <= err;
      i_media_err_type <= t;
      @(posedge i_sys_clk);
      i_media_sector_done <= 1'b0;
      i_media_err <= 1'b0;
    end
  endtask
  // a refused word is left out of the expected stream
  task automatic push(input int k);
    repeat (k) begin
      @(posedge i_sys_clk);
      i_media_valid <= 1'b1;
      i_media_data <= 16'($random(seed));
      @(posedge i_sys_clk);
      if (o_media_ready) exp_q.push_back(i_media_data);
      i_media_valid <= 1'b0;
    end
  endtask
  // done may already stand from the edge at which the previous task returned
  task automatic fin(input int k);
    stop_seen = 1'b0;
    #1;
    for (int j = 0; j < k; j++) begin
      if (o_media_stop === 1'b1) stop_seen = 1'b1;
      if (o_done === 1'b1) break;
      @(posedge i_sys_clk);
      #1;
    end
    elapsed = cyc - elapsed;
  endtask
  function automatic int lim_cyc(input int m, input int dflt);
    int u;
    u = (m != 0 ? m : dflt) * TU;
    if (u == 0) return 0;
    if (u < MINL) u = MINL;
    return u * rsc_pkg::CYCLES_PER_US;
  endfunction
  function automatic logic [7:0] tbit(input logic [1:0] t);
    return 8'h80 >> (t == 2'h0 ? 0 : t == 2'h1 ? 1 : t == 2'h2 ? 3 : 5);
  endfunction
  task automatic results;
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // every word handed to the host must match the media order
  always @(posedge i_sys_clk) if (o_host_valid && i_host_ready) begin
    chk(17'(o_host_data), exp_q.size() > 0 ? 17'(exp_q.pop_front()) : 17'h1FFFF);
  end
  initial begin
    #1500000;
    err_total++;
    results();
  end
  // ======
  // scenarios
  initial begin
    repeat (8) @(posedge i_sys_clk);
    i_sys_rst <= 1'b0;
    rd(rsc_pkg::SEL_STATUS, rsc_pkg::STATUS_RESET);
    rd(rsc_pkg::SEL_ERROR, rsc_pkg::ERROR_RESET);
    rd(3'h6, 8'h00);
    for (i = 0; i < 2; i++) begin
      @(posedge i_sys_clk);
      i_cfg_wr <= 1'b1;
      i_cfg_stream <= i ? 3'h5 : 3'h2;
      i_cfg_default_limit <= i ? 8'h00 : 8'h04;
      @(posedge i_sys_clk);
      i_cfg_wr <= 1'b0;
    end
    cmd(8'h05, 8'hC3, 16'h0002, CMD);
    #1 chk(17'({o_busy, o_media_start, o_media_expedite, o_media_continue, o_media_stream}),
      17'h7B);
    chk(o_media_count, 17'h2);
    chk(17'(o_status), 17'hC0);
    rd(rsc_pkg::SEL_COUNT, 8'h02);
    push(3);
    pulse(1, 1'b1, 2'h1);
    pulse(2, 1'b0, 2'h0);
    fin(300);
    chk(17'(o_status), 17'h60);
    chk(17'(elapsed < lim_cyc(5, 0)), 17'h1);
    rd(rsc_pkg::SEL_LOG, 8'h40);
    for (i = 0; i < 4; i++) begin
      f = 8'($random(seed)) & 8'hB7 | 8'h40;
      n = 16'($random(seed)) & 16'h0003 | 16'h0001;
      sink_mode <= 2'($random(seed)) & 2'h1;
      cmd(8'h32, f, n, CMD);
      @(posedge i_sys_clk);
      #1 chk(17'({o_media_nonseq, o_media_resume, o_media_expedite, o_media_stream}),
        17'({f[5:4], f[7], f[2:0]}));
      chk(o_media_count, 17'(n));
      push(int'(n));
      pulse(1, 1'b1, 2'(i));
      pulse(int'(n), 1'b0, 2'h0);
      fin(3000);
      chk(17'(o_status), 17'h60);
      chk(17'(elapsed < lim_cyc(50, 0)), 17'h1);
      rd(rsc_pkg::SEL_LOG, tbit(2'(i)));
    end
    sink_mode <= 2'h0;
    cmd(8'h32, 8'h01, 16'h0000, CMD);
    @(posedge i_sys_clk);
    #1 chk(o_media_count, rsc_pkg::FULL_SECTOR_COUNT);
    pulse(1, 1'b1, 2'h2);
    fin(50);
    chk({o_status, o_error, stop_seen}, {8'h41, 8'h10, 1'b1});
    for (i = 0; i < 3; i++) begin
      cmd(mv[i], fv[i], 16'h0001, CMD);
      lim = lim_cyc(int'(mv[i]), i == 2 ? 4 : 0);
      fin(400);
      chk(17'(elapsed >= lim && elapsed <= lim + 4), 17'h1);
      chk({o_status, o_error, stop_seen}, fv[i][6] ? {8'h60, 8'h00, 1'b1} : {8'h41, 8'h01, 1'b1});
      if (fv[i][6]) rd(rsc_pkg::SEL_LOG, 8'h01);
    end
    for (i = 0; i < 2; i++) begin
      cmd(8'h00, i ? 8'h07 : 8'h05, 16'h0001, CMD);
      fin(400);
      chk(17'(o_busy), 17'h1);
      pulse(1, 1'b0, 2'h0);
      fin(20);
      chk(17'(o_status), 17'h40);
    end
    sink_mode <= 2'h2;
    cmd(8'h00, 8'h07, 16'h0001, CMD);
    push(20);
    chk(17'(o_media_ready), 17'h0);
    chk(17'(exp_q.size() >= 16 && exp_q.size() <= 17), 17'h1);
    sink_mode <= 2'h0;
    pulse(1, 1'b0, 2'h0);
    fin(200);
    chk(17'(exp_q.size()), 17'h0);
    cmd(8'h00, 8'h00, 16'h0001, 8'hFF);
    fin(5);
    chk({o_status, o_error, o_busy}, {8'h41, 8'h04, 1'b0});
    results();
  end
endmodule // rsc_read_stream_bench
